// File: rtl/eiob_pkg.sv
// Purpose: shared constants and types of the external I/O bank strobe block
// Assumes: 32-bit AHB-Lite register slave, 16-bit processor I/O address
// Notes:   control byte keeps only its upper five bits, low three read zero
package eiob_pkg;

  localparam int          EIOB_BANKS   = 8;
  localparam int          EIOB_AW      = 16;
  localparam int          EIOB_BANK_HI = 15;
  localparam int          EIOB_BANK_LO = 13;

  // ------------------------------------------------------------
  // control byte fields
  // ------------------------------------------------------------
  localparam int          CTL_WS_HI    = 7;
  localparam int          CTL_WS_LO    = 6;
  localparam int          CTL_TYP_HI   = 5;
  localparam int          CTL_TYP_LO   = 4;
  localparam int          CTL_PERMIT   = 3;
  localparam int          CTL_KEPT_LO  = 3;
  localparam logic [4:0]  CTL_RESET    = 5'h00;
  localparam logic [7:0]  DIR_RESET    = 8'h00;
  localparam logic [7:0]  FUNC_RESET   = 8'h00;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0]  OFS_BANK0    = 8'h00;
  localparam logic [7:0]  OFS_DIR      = 8'h20;
  localparam logic [7:0]  OFS_FUNC     = 8'h24;
  localparam logic [7:0]  OFS_STATUS   = 8'h28;
  localparam int          STS_BUSY     = 0;
  localparam int          STS_EXT      = 1;
  localparam int          STS_WRITE    = 2;
  localparam int          STS_BANK_LO  = 4;

  // ------------------------------------------------------------
  // wait state codes and strobe shapes
  // ------------------------------------------------------------
  localparam logic [1:0]  WS_CODE_1    = 2'b11;
  localparam logic [1:0]  WS_CODE_3    = 2'b10;
  localparam logic [1:0]  WS_CODE_7    = 2'b01;
  localparam logic [3:0]  WS_CNT_1     = 4'h1;
  localparam logic [3:0]  WS_CNT_3     = 4'h3;
  localparam logic [3:0]  WS_CNT_7     = 4'h7;
  localparam logic [3:0]  WS_CNT_15    = 4'hf;

  typedef enum logic [1:0] {
    STB_CS = 2'b00,
    STB_RD = 2'b01,
    STB_WR = 2'b10,
    STB_RW = 2'b11
  } eiob_stb_t;

  // gray along idle, first, wait, last
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FIRST = 2'b01,
    ST_WAIT  = 2'b11,
    ST_LAST  = 2'b10
  } eiob_state_t;

  function automatic logic [3:0] eiob_ws_count(input logic [1:0] code);
    logic [3:0] n;
    n = WS_CNT_15;
    case (code)
      WS_CODE_1: n = WS_CNT_1;
      WS_CODE_3: n = WS_CNT_3;
      WS_CODE_7: n = WS_CNT_7;
      default:   n = WS_CNT_15;
    endcase
    return n;
  endfunction

endpackage

// File: rtl/eiob_cyc_if.sv
// Purpose: carries the bus-cycle request and phase between the two modules
// Assumes: single clock domain
// Notes:   next_state is combinational so the top can register strobes
interface eiob_cyc_if;
  import eiob_pkg::*;
  logic        start;
  logic        ext;
  logic [3:0]  ws;
  eiob_state_t state;
  eiob_state_t next_state;
  modport ctl (output start, ext, ws, input state, next_state);
  modport seq (input start, ext, ws, output state, next_state);
endinterface

// File: rtl/eiob_cycle.sv
// Purpose: sequences one I/O bus cycle, first clock, waits, last clock
// Assumes: start is only raised while idle
// Notes:   internal cycles skip the wait phase and last two clocks
module eiob_cycle
  import eiob_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  eiob_cyc_if.seq   cyc
);

  logic [3:0] cnt;

  always_comb
  begin
    cyc.next_state = cyc.state;
    case (cyc.state)
      ST_IDLE:  if (cyc.start) cyc.next_state = ST_FIRST;
      ST_FIRST: cyc.next_state = (cnt == 4'h0) ? ST_LAST : ST_WAIT;
      ST_WAIT:  if (cnt == 4'h1) cyc.next_state = ST_LAST;
      ST_LAST:  cyc.next_state = ST_IDLE;
      default:  cyc.next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      cyc.state <= ST_IDLE;
    else
      cyc.state <= cyc.next_state;
  end

  // wait counter, loaded with zero for internal space
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      cnt <= 4'h0;
    else if (cyc.state == ST_IDLE && cyc.start)
      cnt <= cyc.ext ? cyc.ws : 4'h0;
    else if (cyc.state == ST_WAIT)
      cnt <= cnt - 4'h1;
  end

endmodule

// File: rtl/eiob_ctrl.sv
// Purpose: external I/O bank decode, wait states and per-bank strobes
// Assumes: processor I/O request on clk_sys, AHB-Lite register slave
// Notes:   strobe pins are active low; oe high while a pin is driven
// Summary of operation
// - the bank is picked by address bits 15..13, eight banks of 8K each.
// - each bank has its own control register and drives strobe pin n.
// - bits 7:6 give 1, 3, 7 or 15 wait states for codes 11, 10, 01, 00.
// - wait states apply to every external access whether or not the pin drives.
// - global read and write strobes stretch with the bank's wait states.
// - bits 5:4 shape the bank strobe as chip select, read, write or either.
// - bit 3 low blocks writes on the global write strobe and on write or either shaped bank strobes, not chip select.
// - reset clears the upper five bits of every bank control register.
// - external cycles always have at least one wait, three clocks minimum.
// - internal I/O cycles take two clocks and ignore the bank registers.
// - a bank strobe is driven only when its direction and function bits are set.
module eiob_ctrl
  import eiob_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        io_start,
  input  wire logic        io_external,
  input  wire logic        io_write,
  input  wire logic [15:0] io_addr,
  output logic             io_busy,
  output logic             io_done,
  output logic             global_io_read_strobe_n,
  output logic             global_io_write_strobe_n,
  output logic [7:0]       bank_strobe_n,
  output logic [7:0]       bank_strobe_oe
);

  eiob_cyc_if cyc ();

  logic [4:0]  ctrl [EIOB_BANKS];
  logic [7:0]  port_dir;
  logic [7:0]  port_func;
  logic [2:0]  cur_bank;
  logic        cur_ext;
  logic        cur_write;
  logic        dph_wr;
  logic [7:0]  dph_addr;
  logic        aph_sel;
  logic        aph_hit;
  logic [31:0] rd_mux;
  logic        accept;
  logic [2:0]  nx_bank;
  logic        nx_ext;
  logic        nx_write;
  logic        win;
  logic        act;
  logic        next_grd;
  logic        next_gwr;
  logic [7:0]  next_bank_stb;

  // ------------------------------------------------------------
  // AHB-Lite slave, zero wait, always OKAY
  // ------------------------------------------------------------
  assign aph_sel = hsel && htrans[1] && hready;
  assign aph_hit = (haddr[31:8] == 24'h000000);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      dph_wr   <= 1'b0;
      dph_addr <= 8'h00;
    end
    else if (hready)
    begin
      dph_wr   <= aph_sel && hwrite && aph_hit && haddr[1:0] == 2'b00;
      dph_addr <= haddr[7:0];
    end
  end

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (aph_hit)
    begin
      if (haddr[7:0] < OFS_DIR && haddr[1:0] == 2'b00)
        rd_mux[7:CTL_KEPT_LO] = ctrl[haddr[4:2]];
      else if (haddr[7:0] == OFS_DIR)
        rd_mux[7:0] = port_dir;
      else if (haddr[7:0] == OFS_FUNC)
        rd_mux[7:0] = port_func;
      else if (haddr[7:0] == OFS_STATUS)
      begin
        rd_mux[STS_BUSY]                  = io_busy;
        rd_mux[STS_EXT]                   = cur_ext;
        rd_mux[STS_WRITE]                 = cur_write;
        rd_mux[STS_BANK_LO+2:STS_BANK_LO] = cur_bank;
      end
    end
  end

  // read data ready at the end of the address phase
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      hrdata <= 32'h00000000;
    else if (aph_sel && !hwrite)
      hrdata <= rd_mux;
  end

  // ------------------------------------------------------------
  // bank control registers
  // ------------------------------------------------------------
  for (genvar b = 0; b < EIOB_BANKS; b++)
  begin : g_ctrl
    always_ff @(posedge clk_sys)
    begin
      if (!rst_n)
        ctrl[b] <= CTL_RESET;
      else if (dph_wr && dph_addr == OFS_BANK0 + 8'(b * 4))
        ctrl[b] <= hwdata[7:CTL_KEPT_LO];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      port_dir  <= DIR_RESET;
      port_func <= FUNC_RESET;
    end
    else if (dph_wr && dph_addr == OFS_DIR)
      port_dir  <= hwdata[7:0];
    else if (dph_wr && dph_addr == OFS_FUNC)
      port_func <= hwdata[7:0];
  end

  // ------------------------------------------------------------
  // bus cycle request
  // ------------------------------------------------------------
  assign accept    = io_start && cyc.state == ST_IDLE;
  assign cyc.start = accept;
  assign cyc.ext   = io_external;
  // internal space never sees the bank code
  assign cyc.ws    = io_external ?
                     eiob_ws_count(ctrl[io_addr[EIOB_BANK_HI:EIOB_BANK_LO]][4:3]) :
                     4'h0;

  assign nx_bank  = accept ? io_addr[EIOB_BANK_HI:EIOB_BANK_LO] : cur_bank;
  assign nx_ext   = accept ? io_external : cur_ext;
  assign nx_write = accept ? io_write : cur_write;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cur_bank  <= 3'h0;
      cur_ext   <= 1'b0;
      cur_write <= 1'b0;
    end
    else if (accept)
    begin
      cur_bank  <= nx_bank;
      cur_ext   <= nx_ext;
      cur_write <= nx_write;
    end
  end

  eiob_cycle u_cycle (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .cyc     (cyc)
  );

  // ------------------------------------------------------------
  // strobes, computed from the next phase so flops line up
  // ------------------------------------------------------------
  assign act      = cyc.next_state != ST_IDLE;
  assign win      = cyc.next_state == ST_WAIT || cyc.next_state == ST_LAST;
  assign next_grd = nx_ext && !nx_write && win;
  assign next_gwr = nx_ext && nx_write && win
                    && ctrl[nx_bank][CTL_PERMIT - CTL_KEPT_LO];

  for (genvar i = 0; i < EIOB_BANKS; i++)
  begin : g_stb
    logic sel;
    assign sel = nx_ext && act && nx_bank == 3'(i);
    always_comb
    begin
      case (eiob_stb_t'(ctrl[i][2:1]))
        STB_CS:  next_bank_stb[i] = sel;
        STB_RD:  next_bank_stb[i] = sel && next_grd;
        STB_WR:  next_bank_stb[i] = sel && next_gwr;
        STB_RW:  next_bank_stb[i] = sel && (next_grd || next_gwr);
        default: next_bank_stb[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      global_io_read_strobe_n  <= 1'b1;
      global_io_write_strobe_n <= 1'b1;
      bank_strobe_n            <= 8'hff;
    end
    else
    begin
      global_io_read_strobe_n  <= !next_grd;
      global_io_write_strobe_n <= !next_gwr;
      bank_strobe_n            <= ~next_bank_stb;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      bank_strobe_oe <= 8'h00;
    else
      bank_strobe_oe <= port_dir & port_func;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      io_busy <= 1'b0;
      io_done <= 1'b0;
    end
    else
    begin
      io_busy <= act;
      io_done <= cyc.next_state == ST_LAST;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_bank_decode;
    @(posedge clk_sys) disable iff (!rst_n)
    accept |=> cur_bank == $past(io_addr[15:13]);
  endproperty
  a_bank_decode: assert property (p_bank_decode)
    else $error("bank not taken from address bits 15..13");

  property p_internal_two;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && !io_external |=> !io_done ##1 io_done;
  endproperty
  a_internal_two: assert property (p_internal_two)
    else $error("internal cycle not two clocks");

  property p_ext_min_three;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && io_external && ctrl[io_addr[15:13]][4:3] == WS_CODE_1
      |=> !io_done [*2] ##1 io_done;
  endproperty
  a_ext_min_three: assert property (p_ext_min_three)
    else $error("one-wait external cycle not three clocks");

  property p_ext_seven;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && io_external && ctrl[io_addr[15:13]][4:3] == WS_CODE_7
      |=> !io_done [*8] ##1 io_done;
  endproperty
  a_ext_seven: assert property (p_ext_seven)
    else $error("seven-wait cycle length wrong");

  property p_write_inhibit;
    @(posedge clk_sys) disable iff (!rst_n)
    !global_io_write_strobe_n |-> cur_ext && cur_write
      && ctrl[cur_bank][CTL_PERMIT - CTL_KEPT_LO];
  endproperty
  a_write_inhibit: assert property (p_write_inhibit)
    else $error("write strobe while writes inhibited");

  property p_strobe_oe;
    @(posedge clk_sys) disable iff (!rst_n)
    ##1 bank_strobe_oe == $past(port_dir & port_func);
  endproperty
  a_strobe_oe: assert property (p_strobe_oe)
    else $error("strobe enable not direction and function");

  property p_bank_only;
    @(posedge clk_sys) disable iff (!rst_n)
    bank_strobe_n != 8'hff |-> io_busy && cur_ext
      && ~bank_strobe_n == (8'h01 << cur_bank);
  endproperty
  a_bank_only: assert property (p_bank_only)
    else $error("bank strobe outside its own external cycle");

  property p_read_stretch;
    @(posedge clk_sys) disable iff (!rst_n)
    !global_io_read_strobe_n && !io_done |=> !global_io_read_strobe_n;
  endproperty
  a_read_stretch: assert property (p_read_stretch)
    else $error("read strobe released before the last clock");

  property p_read_in_cycle;
    @(posedge clk_sys) disable iff (!rst_n)
    !global_io_read_strobe_n |-> io_busy && cur_ext && !cur_write;
  endproperty
  a_read_in_cycle: assert property (p_read_in_cycle)
    else $error("read strobe outside external read");

  property p_reset_clear;
    @(posedge clk_sys)
    !rst_n |=> ctrl[0] == CTL_RESET && ctrl[7] == CTL_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("bank control not cleared by reset");

  property p_cs_window;
    @(posedge clk_sys) disable iff (!rst_n)
    accept && io_external
      && ctrl[io_addr[15:13]][2:1] == STB_CS
      |=> !bank_strobe_n[cur_bank] [*2];
  endproperty
  a_cs_window: assert property (p_cs_window)
    else $error("chip select not held from first clock");

endmodule

// File: test/eiob_periph.sv
// Purpose: external peripheral chips watching the I/O bus strobes
// Assumes: bank pins are pulled up while their output is not enabled
// Notes:   counts low clocks of the read strobe, the write strobe and any driven bank pin since the last clr
module eiob_periph
(
  input  wire logic        clk_sys,
  input  wire logic        clr,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  stb_n,
  input  wire logic [7:0]  oe,
  output logic      [31:0] rd_cnt,
  output logic      [31:0] wr_cnt,
  output logic      [31:0] bk_cnt,
  output logic      [31:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pin_low;

  // undriven pin reads high through its pull-up
  assign pin_low = oe & ~stb_n;

  always_ff @(posedge clk_sys)
  begin
    if (clr)
    begin
      rd_cnt <= 32'h0;
      wr_cnt <= 32'h0;
      bk_cnt <= 32'h0;
      seen   <= 32'h0;
    end
    else
    begin
      rd_cnt <= rd_cnt + {31'h0, ~rd_n};
      wr_cnt <= wr_cnt + {31'h0, ~wr_n};
      bk_cnt <= bk_cnt + {31'h0, |pin_low};
      seen   <= seen | {24'h0, pin_low};
    end
  end
endmodule

// File: test/external_io_bank_strobe_ctrl_tb_top.sv
// Purpose: self-checking bench of the external I/O bank strobe block
// Assumes: hreadyout fed back as hready, single word transfers
// Notes:   strobe widths measured by the peripheral model
module external_io_bank_strobe_ctrl_tb_top
  import eiob_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WT[4] = '{15, 7, 3, 1};
  logic        clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, clr = 1'b0;
  logic        io_start = 1'b0, io_external = 1'b0, io_write = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [15:0] io_addr = 16'h0;
  logic        hreadyout, hresp, io_busy, io_done, grd_n, gwr_n;
  logic [7:0]  stb_n, stb_oe;
  logic [31:0] rd_cnt, wr_cnt, bk_cnt, seen;
  int          error_cnt = 0, cmp_count = 0, cyc_cnt = 0;

  always #5 clk_sys = ~clk_sys;

  eiob_ctrl uut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .io_start(io_start), .io_external(io_external), .io_write(io_write),
    .io_addr(io_addr), .io_busy(io_busy), .io_done(io_done),
    .global_io_read_strobe_n(grd_n), .global_io_write_strobe_n(gwr_n),
    .bank_strobe_n(stb_n), .bank_strobe_oe(stb_oe));

  eiob_periph u_periph (.clk_sys(clk_sys), .clr(clr), .rd_n(grd_n), .wr_n(gwr_n),
    .stb_n(stb_n), .oe(stb_oe), .rd_cnt(rd_cnt), .wr_cnt(wr_cnt), .bk_cnt(bk_cnt),
    .seen(seen));

  // ------------------------------------------------------------
  // checks and bus tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk("hrdata", e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // one processor I/O cycle, then cycle length and strobe widths
  task automatic io(input logic ext, input logic w, input logic [15:0] a, input int n,
                    input int r, input int q, input int b, input logic [7:0] s);
    int k;
    @(posedge clk_sys);
    io_start    <= 1'b1;
    io_external <= ext;
    io_write    <= w;
    io_addr     <= a;
    clr         <= 1'b1;
    @(posedge clk_sys);
    io_start <= 1'b0;
    clr      <= 1'b0;
    k = 0;
    #1;
    chk("busy", 32'h1, {31'h0, io_busy});
    while (io_done !== 1'b1 && k < 40)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    repeat (2) @(posedge clk_sys);
    #1;
    chk("cycle", n - 1, k);
    chk("idle", 32'h0, {31'h0, io_busy});
    chk("read strobe", r, rd_cnt);
    chk("write strobe", q, wr_cnt);
    chk("bank strobe", b, bk_cnt);
    chk("bank pins", {24'h0, s}, seen);
  endtask

  always @(posedge clk_sys)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [1:0] c, t;
    logic [7:0] s;
    int w, e, r, q;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(8'(4 * i), 32'h0);
    rdc(OFS_DIR, 32'h0);
    wr(8'h40, 32'hff);
    rdc(8'h40, 32'h0);
    wr(OFS_DIR, 32'hff);
    wr(OFS_FUNC, 32'h0f);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("oe", 32'h0f, {24'h0, stb_oe});
    wr(OFS_FUNC, 32'hff);
    for (int b = 0; b < 8; b++)
    begin
      c = b[1:0];
      t = b[2:1];
      w = WT[c];
      wr(8'(4 * b), {24'h0, c, t, 4'hf});
      rdc(8'(4 * b), {24'h0, c, t, 4'h8});
      for (int m = 0; m < 2; m++)
      begin
        e = (t == 2'b00) ? w + 2 : (t == 2'b11 || t == 2'(m + 1)) ? w + 1 : 0;
        r = m ? 0 : w + 1;
        q = m ? w + 1 : 0;
        s = e ? 8'(1 << b) : 8'h0;
        io(1'b1, m[0], {b[2:0], 13'h0abc}, w + 2, r, q, e, s);
      end
    end
    wr(8'h18, 32'hb0);
    io(1'b1, 1'b1, 16'hc001, 5, 0, 0, 0, 8'h0);
    io(1'b1, 1'b0, 16'hdfff, 5, 4, 0, 4, 8'h40);
    io(1'b0, 1'b0, 16'h0123, 2, 0, 0, 0, 8'h0);
    io(1'b0, 1'b1, 16'h0123, 2, 0, 0, 0, 8'h0);
    wr(OFS_FUNC, 32'hfd);
    io(1'b1, 1'b0, 16'h2000, 9, 8, 0, 0, 8'h0);
    rdc(OFS_STATUS, 32'h12);
    stop_test();
  end
endmodule
